// file: bench/rtcsp_host_model.sv
// Host processor model for the three-wire serial port.
// Assumes the bench resolves the shared data line from both drive enables.
`timescale 1ns/1ps
`default_nettype none

module rtcsp_host_model
(
  input wire logic line_level,
  output logic chip_enable,
  output logic serial_clock,
  output logic host_bit,
  output logic host_drive,
  output logic read_window
);
  // ****************************************
  // Session framing and byte shifting
  // ****************************************
  initial
  begin
    chip_enable = 1'b0;
    serial_clock = 1'b0;
    host_bit = 1'b0;
    host_drive = 1'b0;
    read_window = 1'b0;
  end

  // Clock level at the enable rise chooses the edge pairing
  task automatic start(input logic mode);
    serial_clock = mode;
    #16;
    chip_enable = 1'b1;
    #32;
  endtask

  // Host lets go of the line while the device shifts a read byte out
  task automatic xfer(input logic [7:0] tx, input logic rd, input int nbits,
    output logic [7:0] rx);
    if (read_window && !rd)
    begin
      // Wait out the device release before driving again
      #32;
      read_window = 1'b0;
    end
    rx = 8'h00;
    read_window = read_window | rd;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      host_drive = !rd;
      host_bit = tx[i];
      #16;
      serial_clock = !serial_clock;
      #32;
      rx[i] = line_level;
      serial_clock = !serial_clock;
      #16;
    end
    host_drive = 1'b0;
  endtask

  // Sessions here outlast the shortened carry hold limit of the bench
  task automatic stop();
    #16;
    chip_enable = 1'b0;
    #64;
    read_window = 1'b0;
  endtask
endmodule

`default_nettype wire

// file: bench/test_rtc_three_wire_port_alarm_regs.sv
// Self-checking bench for the serial port and its alarm registers.
// Assumes the host model in the same folder; carry hold is shortened.
`timescale 1ns/1ps
`default_nettype none

module test_rtc_three_wire_port_alarm_regs;
  import rtcsp_pkg::*;
  localparam int HOLD = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [2:0] weekday_count = 3'h0;
  logic chip_enable, serial_clock, host_bit, host_drive, read_window;
  logic dut_out, dut_oe_n, carry_hold, weekly_day_match;
  logic [7:0] weekly_day_select, daily_minute, daily_hour;
  logic float_bit = 1'b0;
  logic line_level;
  int fails = 0;
  int checks = 0;

  // ****************************************
  // Clock, wire and instances
  // ****************************************
  always #4 clk = ~clk;
  // A released line wanders so a stale level never passes for data
  always @(posedge clk) float_bit <= ~float_bit;
  assign line_level = !dut_oe_n ? dut_out : host_drive ? host_bit : float_bit;

  rtcsp_top #(.HOLD_CYCLES(HOLD)) u_dut (
    .clk(clk), .rst(rst), .clk_en(clk_en), .chip_enable(chip_enable),
    .serial_clock(serial_clock), .serial_data_io_in(line_level),
    .serial_data_io_out(dut_out), .serial_data_io_oe_n(dut_oe_n),
    .weekday_count(weekday_count), .carry_hold(carry_hold),
    .weekly_day_match(weekly_day_match),
    .weekly_day_select(weekly_day_select), .daily_minute(daily_minute),
    .daily_hour(daily_hour));

  rtcsp_host_model u_host (
    .line_level(line_level), .chip_enable(chip_enable),
    .serial_clock(serial_clock), .host_bit(host_bit),
    .host_drive(host_drive), .read_window(read_window));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic chk8(input string name, input logic [7:0] exp,
    input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  always @(posedge clk)
    if (!rst && dut_oe_n !== 1'b1 && !read_window)
    begin
      fails++;
      $display("ERROR line_drive expected 1 seen %b", dut_oe_n);
    end

  function automatic logic [7:0] port_of(input int i);
    return i == 0 ? weekly_day_select : i == 1 ? daily_minute : daily_hour;
  endfunction

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic m);
    logic [7:0] rx;
    u_host.start(m);
    u_host.xfer({a, FMT_SINGLE_WRITE}, 1'b0, 8, rx);
    u_host.xfer(d, 1'b0, 8, rx);
    u_host.stop();
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d, input logic m);
    logic [7:0] rx;
    u_host.start(m);
    u_host.xfer({a, FMT_SINGLE_READ}, 1'b0, 8, rx);
    u_host.xfer(8'h00, 1'b1, 8, d);
    u_host.stop();
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk8("day_select", 8'h00, weekly_day_select);
    chk8("minute", 8'h00, daily_minute);
    chk8("hour", 8'h00, daily_hour);
    chk8("oe_n", 8'h01, {7'h00, dut_oe_n});
  endtask

  // Legal times only: 23h, noon as 32 in 12-hour form
  task automatic t_single();
    logic [3:0] addrs [3] = '{4'hA, 4'hB, 4'hC};
    logic [7:0] masks [3] = '{8'h7F, 8'h7F, 8'h3F};
    logic [7:0] vals [6] = '{8'hFF, 8'hD9, 8'hE3, 8'h2A, 8'h30, 8'h32};
    logic [7:0] got;
    logic [7:0] exp;
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 3; i++)
      begin
        wr(addrs[i], vals[m * 3 + i], m[0]);
        rd(addrs[i], got, m[0]);
        exp = vals[m * 3 + i] & masks[i];
        chk8("read_back", exp, got);
        chk8("reg_port", exp, port_of(i));
      end
  endtask

  // Burst across the pointer wrap and through addresses outside the block
  task automatic t_burst();
    logic [7:0] rx;
    logic [7:0] exp;
    u_host.start(1'b0);
    u_host.xfer({4'hE, FMT_BURST_WRITE}, 1'b0, 8, rx);
    for (int i = 0; i < 14; i++)
    begin
      exp = i == 12 ? 8'h41 : i == 13 ? 8'h15 : 8'h00;
      u_host.xfer(exp, 1'b0, 8, rx);
    end
    u_host.stop();
    u_host.start(1'b1);
    u_host.xfer({4'hF, FMT_BURST_READ}, 1'b0, 8, rx);
    for (int i = 0; i < 14; i++)
    begin
      u_host.xfer(8'h00, 1'b1, 8, rx);
      exp = i == 11 ? 8'h41 : i == 12 ? 8'h15 : i == 13 ? 8'h32 : 8'h00;
      chk8("burst_read", exp, rx);
    end
    u_host.stop();
  endtask

  // Read-modify-write, cut-off byte and an unknown format code
  task automatic t_mixed();
    logic [7:0] rx;
    u_host.start(1'b0);
    u_host.xfer({ADDR_DAILY_HOUR, FMT_SINGLE_READ}, 1'b0, 8, rx);
    u_host.xfer(8'h00, 1'b1, 8, rx);
    chk8("rmw_read", 8'h32, rx);
    u_host.xfer({ADDR_DAILY_MINUTE, FMT_SINGLE_WRITE}, 1'b0, 8, rx);
    u_host.xfer(8'h45, 1'b0, 8, rx);
    u_host.xfer({ADDR_DAILY_MINUTE, FMT_SINGLE_READ}, 1'b0, 8, rx);
    u_host.xfer(8'h00, 1'b1, 8, rx);
    chk8("rmw_minute", 8'h45, rx);
    u_host.xfer({ADDR_WEEKLY_DAY, FMT_SINGLE_WRITE}, 1'b0, 8, rx);
    u_host.xfer(8'h7F, 1'b0, 4, rx);
    u_host.stop();
    u_host.start(1'b1);
    u_host.xfer({ADDR_WEEKLY_DAY, 4'h2}, 1'b0, 8, rx);
    u_host.xfer(8'h7F, 1'b0, 8, rx);
    u_host.stop();
    chk8("day_kept", 8'h41, weekly_day_select);
  endtask

  // Clock enable low must freeze the match flop against a new weekday
  task automatic t_freeze();
    @(posedge clk);
    #1 weekday_count = 3'h0;
    repeat (2) @(posedge clk);
    #1 clk_en = 1'b0;
    weekday_count = 3'h1;
    repeat (4) @(posedge clk);
    #1 chk8("frozen_match", 8'h01, {7'h00, weekly_day_match});
    clk_en = 1'b1;
    repeat (2) @(posedge clk);
    #1 chk8("thawed_match", 8'h00, {7'h00, weekly_day_match});
  endtask

  task automatic t_weekday();
    logic [7:0] sel;
    logic [7:0] hit;
    for (int k = 0; k < 2; k++)
    begin
      sel = k == 0 ? 8'h41 : 8'h00;
      if (k == 1)
        wr(ADDR_WEEKLY_DAY, sel, 1'b0);
      for (int w = 0; w < 8; w++)
      begin
        @(posedge clk);
        #1 weekday_count = w[2:0];
        repeat (3) @(posedge clk);
        #1 hit = {7'h00, w < 7 && sel[w]};
        chk8("day_match", hit, {7'h00, weekly_day_match});
      end
    end
  endtask

  task automatic t_carry();
    int n;
    n = 0;
    u_host.start(1'b0);
    while (carry_hold !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk8("hold_rise", 8'h01, {7'h00, carry_hold});
    // A hold that never rose is already counted; the report follows
    if (carry_hold !== 1'b1)
    begin
      u_host.stop();
      return;
    end
    repeat (HOLD / 2) @(posedge clk);
    #1 chk8("hold_mid", 8'h01, {7'h00, carry_hold});
    repeat (HOLD / 2 + 8) @(posedge clk);
    #1 chk8("hold_limit", 8'h00, {7'h00, carry_hold});
    u_host.stop();
  endtask

  task automatic report_and_stop();
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_single();
    t_burst();
    t_mixed();
    t_freeze();
    t_weekday();
    t_carry();
    report_and_stop();
  end

  initial
  begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule

`default_nettype wire

// file: core/rtcsp_alarm_regs.sv
// Weekly day-select and daily minute/hour alarm registers.
// Assumes weekday_count comes from logic on clk.
`timescale 1ns/1ps
`default_nettype none

module rtcsp_alarm_regs
  import rtcsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  rtcsp_reg_if.regs bus,
  input wire logic [2:0] weekday_count,
  output logic [BYTE_BITS-1:0] weekly_day_select,
  output logic [BYTE_BITS-1:0] daily_minute,
  output logic [BYTE_BITS-1:0] daily_hour,
  output logic weekly_day_match
);

  function automatic logic [BYTE_BITS-1:0] read_mux(
    input logic [ADDR_W-1:0] a,
    input logic [BYTE_BITS-1:0] wk,
    input logic [BYTE_BITS-1:0] mi,
    input logic [BYTE_BITS-1:0] hr
  );
    case (a)
      ADDR_WEEKLY_DAY: read_mux = wk & WEEKLY_DAY_MASK;
      ADDR_DAILY_MINUTE: read_mux = mi & DAILY_MINUTE_MASK;
      ADDR_DAILY_HOUR: read_mux = hr & DAILY_HOUR_MASK;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  // Contents are arbitrary data after power-up; zero is simply defined
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      weekly_day_select <= ALARM_RESET; // RULE20
      daily_minute <= ALARM_RESET;
      daily_hour <= ALARM_RESET;
    end
    else if (clk_en && bus.wr_en)
    begin
      if (bus.addr == ADDR_WEEKLY_DAY)
        weekly_day_select <= bus.wdata & WEEKLY_DAY_MASK; // RULE12
      if (bus.addr == ADDR_DAILY_MINUTE)
        daily_minute <= bus.wdata & DAILY_MINUTE_MASK; // RULE15
      if (bus.addr == ADDR_DAILY_HOUR)
        daily_hour <= bus.wdata & DAILY_HOUR_MASK; // RULE16 RULE17 RULE18
    end
  end

  assign bus.rdata = read_mux(bus.addr, weekly_day_select, daily_minute,
    daily_hour);

  // ****************************************
  // Weekly day match
  // ****************************************
  // Counter value 7 never selects a day, so an all-zero mask never matches
  always_ff @(posedge clk)
  begin
    if (rst)
      weekly_day_match <= 1'b0;
    else if (clk_en)
      weekly_day_match <= (weekday_count != WEEKDAY_UNUSED) &&
        weekly_day_select[weekday_count]; // RULE13 RULE14
  end

  chk_weekly_none_match: assert property (@(posedge clk) disable iff (rst)
    (clk_en && weekly_day_select[WEEKDAYS-1:0] == 7'h00) |=>
    !weekly_day_match) // RULE14
    else $error("weekly match with no day selected");

  chk_reg_top_zero: assert property (@(posedge clk) disable iff (rst)
    (weekly_day_select[7] == 1'b0) && (daily_minute[7] == 1'b0) &&
    (daily_hour[7:6] == 2'h0)) // RULE12
    else $error("alarm register unused bit set");

endmodule

`default_nettype wire

// file: core/rtcsp_pin_sync.sv
// Two-flop synchroniser for the serial port pins.
// Assumes the pins are asynchronous to clk; no logic reads the first stage.
`timescale 1ns/1ps
`default_nettype none

module rtcsp_pin_sync
  import rtcsp_pkg::*;
#(
  parameter int WIDTH = 3
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_reg;

  // ****************************************
  // Synchroniser stages
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      pin_sync <= '0;
    end
    else if (clk_en)
    begin
      meta_reg <= pin_async;
      pin_sync <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// file: core/rtcsp_pkg.sv
// Constants and types shared by the three-wire port and its alarm registers.
// Assumes a 125 MHz system clock; serial pins are asynchronous to it.

package rtcsp_pkg;

  // ****************************************
  // Serial framing
  // ****************************************
  localparam int BYTE_BITS = 8;
  localparam int ADDR_W = 4;
  localparam int FMT_W = 4;
  localparam int BIT_CNT_W = 3;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 3'h7;
  localparam int SYNC_STAGES = 2;

  // Transfer format codes
  localparam logic [FMT_W-1:0] FMT_SINGLE_WRITE = 4'h8;
  localparam logic [FMT_W-1:0] FMT_BURST_WRITE = 4'h0;
  localparam logic [FMT_W-1:0] FMT_SINGLE_READ = 4'hC;
  localparam logic [FMT_W-1:0] FMT_BURST_READ = 4'h4;

  // ****************************************
  // Alarm register map
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_WEEKLY_DAY = 4'hA;
  localparam logic [ADDR_W-1:0] ADDR_DAILY_MINUTE = 4'hB;
  localparam logic [ADDR_W-1:0] ADDR_DAILY_HOUR = 4'hC;
  localparam logic [BYTE_BITS-1:0] WEEKLY_DAY_MASK = 8'h7F;
  localparam logic [BYTE_BITS-1:0] DAILY_MINUTE_MASK = 8'h7F;
  localparam logic [BYTE_BITS-1:0] DAILY_HOUR_MASK = 8'h3F;
  localparam int DAILY_PM_FLAG_BIT = 5;
  localparam logic [BYTE_BITS-1:0] ALARM_RESET = 8'h00;
  localparam int WEEKDAYS = 7;
  localparam logic [2:0] WEEKDAY_UNUSED = 3'h7;

  // ****************************************
  // Carry hold timing
  // ****************************************
  localparam longint CLK_PERIOD_PS = 8000;
  localparam longint CARRY_HOLD_US = 1000000;
  localparam int CARRY_HOLD_CYCLES =
    int'((CARRY_HOLD_US * 1000) / CLK_PERIOD_PS);
  localparam int HOLD_CNT_W = 27;

  typedef enum {
    RTCSP_IDLE,
    RTCSP_CMD,
    RTCSP_WRITE,
    RTCSP_READ,
    RTCSP_IGNORE
  } rtcsp_state_e;

endpackage

// file: core/rtcsp_reg_if.sv
// Register access channel between the serial port engine and alarm registers.
// Assumes both ends run on the same clock; addr comes straight from a register, the rest is combinational.
`timescale 1ns/1ps
`default_nettype none

interface rtcsp_reg_if;
  import rtcsp_pkg::*;
  logic wr_en;
  logic [ADDR_W-1:0] addr;
  logic [BYTE_BITS-1:0] wdata;
  logic [BYTE_BITS-1:0] rdata;

  modport port (output wr_en, output addr, output wdata, input rdata);
  modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// file: core/rtcsp_top.sv
// Three-wire serial host port with its weekly and daily alarm registers.
// Assumes chip_enable, serial_clock and data pin are asynchronous to clk.
//
// Behaviour
// RULE1: Port uses chip enable, serial clock and one two-way data line.
// RULE2: Clock low at enable rise: drive on rising, sample on falling.
// RULE3: Clock high at enable rise: drive on falling, sample on rising.
// RULE4: Session spans enable high; data moves in whole bytes.
// RULE5: First byte: upper nibble is address, lower nibble is format.
// RULE6: Every byte shifts most significant bit first.
// RULE7: Format 8h writes one byte, then expects a new command byte.
// RULE8: Format 0h burst-writes, pointer increments and wraps Fh to 0h.
// RULE9: Format Ch reads one byte, then expects a new command byte.
// RULE10: Format 4h burst-reads, pointer increments and wraps Fh to 0h.
// RULE11: Hold seconds carry while enable high, at most one second; the code drops the hold after 124999 cycles (CARRY_HOLD_CYCLES is 125000).
// RULE12: Weekly day-select at Ah, bits 6..0; bit 7 reads zero.
// RULE13: Day-select bit n matches weekday counter value n, 0 to 6.
// RULE14: No day selected means weekly alarm never matches.
// RULE15: Daily minute at Bh, bits 6..0; bit 7 reads zero.
// RULE16: Daily hour at Ch, bits 5..0; bits 7 and 6 read zero.
// RULE17: Hour bit 5 is PM flag or twenties digit by mode.
// RULE18: In 12-hour mode midnight is 12 and noon is 32.
// RULE19: Host must never write impossible alarm times.
// RULE20: Alarm fields are arbitrary after power-up; unused bits read zero.
// RULE21: Data line driven only while shifting out read bytes.
`timescale 1ns/1ps
`default_nettype none

module rtcsp_top
  import rtcsp_pkg::*;
#(
  parameter int HOLD_CYCLES = CARRY_HOLD_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic chip_enable,
  input wire logic serial_clock,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe_n,
  input wire logic [2:0] weekday_count,
  output logic carry_hold,
  output logic weekly_day_match,
  output logic [BYTE_BITS-1:0] weekly_day_select,
  output logic [BYTE_BITS-1:0] daily_minute,
  output logic [BYTE_BITS-1:0] daily_hour
);

  function automatic rtcsp_state_e fmt_state(input logic [FMT_W-1:0] f);
    case (f)
      FMT_SINGLE_WRITE: fmt_state = RTCSP_WRITE;
      FMT_BURST_WRITE: fmt_state = RTCSP_WRITE;
      FMT_SINGLE_READ: fmt_state = RTCSP_READ;
      FMT_BURST_READ: fmt_state = RTCSP_READ;
      default: fmt_state = RTCSP_IGNORE;
    endcase
  endfunction

  rtcsp_reg_if reg_bus ();

  logic [2:0] pins_sync;
  logic ce_s;
  logic sclk_s;
  logic sio_s;
  logic ce_d_reg;
  logic sclk_d_reg;
  logic ce_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sample_edge;
  logic launch_edge;
  logic byte_done;
  logic single_fmt;
  logic [BYTE_BITS-1:0] in_byte;
  rtcsp_state_e state_reg;
  logic mode_reg;
  logic [BIT_CNT_W-1:0] bit_cnt_reg;
  logic [BYTE_BITS-1:0] in_sh_reg;
  logic [BYTE_BITS-1:0] out_sh_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [FMT_W-1:0] fmt_reg;
  logic [HOLD_CNT_W-1:0] hold_cnt_reg;

  // ****************************************
  // Pin synchronisation and edge detection
  // ****************************************
  // Clock and data share one delay, so sampling order is preserved
  rtcsp_pin_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .pin_async({chip_enable, serial_clock, serial_data_io_in}), // RULE1
    .pin_sync(pins_sync)
  );

  assign ce_s = pins_sync[2];
  assign sclk_s = pins_sync[1];
  assign sio_s = pins_sync[0];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ce_d_reg <= 1'b0;
      sclk_d_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      ce_d_reg <= ce_s;
      sclk_d_reg <= sclk_s;
    end
  end

  assign ce_rise = ce_s && !ce_d_reg;
  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;
  assign sample_edge = mode_reg ? sclk_rise : sclk_fall; // RULE2 RULE3
  assign launch_edge = mode_reg ? sclk_fall : sclk_rise; // RULE2 RULE3
  assign byte_done = sample_edge && (bit_cnt_reg == LAST_BIT); // RULE4
  assign single_fmt = fmt_reg[3];
  assign in_byte = {in_sh_reg[BYTE_BITS-2:0], sio_s}; // RULE6

  // ****************************************
  // Edge mode, latched at session start
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
      mode_reg <= 1'b0;
    else if (clk_en && state_reg == RTCSP_IDLE && ce_rise)
      mode_reg <= sclk_s; // RULE2 RULE3
  end

  // ****************************************
  // Session state
  // ****************************************
  // Unknown format codes park the session until enable falls
  always_ff @(posedge clk)
  begin
    if (rst)
      state_reg <= RTCSP_IDLE;
    else if (clk_en)
    begin
      if (!ce_s)
        state_reg <= RTCSP_IDLE; // RULE4
      else
      begin
        case (state_reg)
          RTCSP_IDLE:
            if (ce_rise)
              state_reg <= RTCSP_CMD; // RULE4
          RTCSP_CMD:
            if (byte_done)
              state_reg <= fmt_state(in_byte[FMT_W-1:0]); // RULE5
          RTCSP_WRITE:
            if (byte_done && single_fmt)
              state_reg <= RTCSP_CMD; // RULE7
          RTCSP_READ:
            if (byte_done && single_fmt)
              state_reg <= RTCSP_CMD; // RULE9
          RTCSP_IGNORE:
            state_reg <= RTCSP_IGNORE;
          default:
            state_reg <= RTCSP_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // Bit counter and input shifter
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bit_cnt_reg <= '0;
      in_sh_reg <= '0;
    end
    else if (clk_en)
    begin
      if (state_reg == RTCSP_IDLE)
        bit_cnt_reg <= '0;
      else if (sample_edge)
      begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1; // RULE4
        in_sh_reg <= in_byte; // RULE6
      end
    end
  end

  // ****************************************
  // Address pointer and format register
  // ****************************************
  // Four-bit pointer wraps from Fh to 0h by itself
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_reg <= '0;
      fmt_reg <= '0;
    end
    else if (clk_en && ce_s && byte_done)
    begin
      if (state_reg == RTCSP_CMD)
      begin
        addr_reg <= in_byte[BYTE_BITS-1:FMT_W]; // RULE5
        fmt_reg <= in_byte[FMT_W-1:0]; // RULE5
      end
      else if ((state_reg == RTCSP_WRITE || state_reg == RTCSP_READ) &&
        !single_fmt)
        addr_reg <= addr_reg + 4'h1; // RULE8 RULE10
    end
  end

  // ****************************************
  // Register access
  // ****************************************
  assign reg_bus.wr_en = clk_en && ce_s && byte_done &&
    (state_reg == RTCSP_WRITE); // RULE7 RULE8
  assign reg_bus.addr = addr_reg;
  assign reg_bus.wdata = in_byte;

  rtcsp_alarm_regs u_regs (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .bus(reg_bus.regs),
    .weekday_count(weekday_count),
    .weekly_day_select(weekly_day_select),
    .daily_minute(daily_minute),
    .daily_hour(daily_hour),
    .weekly_day_match(weekly_day_match)
  );

  // ****************************************
  // Read data output
  // ****************************************
  // Each byte is fetched at its first launch edge, after the pointer moved
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      serial_data_io_out <= 1'b0;
      out_sh_reg <= '0;
    end
    else if (clk_en && state_reg == RTCSP_READ && launch_edge)
    begin
      if (bit_cnt_reg == '0)
      begin
        serial_data_io_out <= reg_bus.rdata[BYTE_BITS-1]; // RULE6 RULE9
        out_sh_reg <= {reg_bus.rdata[BYTE_BITS-2:0], 1'b0}; // RULE10
      end
      else
      begin
        serial_data_io_out <= out_sh_reg[BYTE_BITS-1]; // RULE6
        out_sh_reg <= {out_sh_reg[BYTE_BITS-2:0], 1'b0};
      end
    end
  end

  // A single read releases at its last sample edge so the host can turn the line around; a burst read holds until enable falls
  always_ff @(posedge clk)
  begin
    if (rst)
      serial_data_io_oe_n <= 1'b1;
    else if (clk_en)
    begin
      if (!ce_s || state_reg != RTCSP_READ || (byte_done && single_fmt))
        serial_data_io_oe_n <= 1'b1; // RULE21
      else if (launch_edge)
        serial_data_io_oe_n <= 1'b0; // RULE21
    end
  end

  // ****************************************
  // Seconds carry hold
  // ****************************************
  // Saturates so a stuck enable cannot stall timekeeping past the limit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hold_cnt_reg <= '0;
      carry_hold <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!ce_s)
      begin
        hold_cnt_reg <= '0;
        carry_hold <= 1'b0; // RULE11
      end
      else
      begin
        if (hold_cnt_reg < HOLD_CNT_W'(HOLD_CYCLES))
          hold_cnt_reg <= hold_cnt_reg + 27'h1;
        carry_hold <= (hold_cnt_reg < HOLD_CNT_W'(HOLD_CYCLES - 1)); // RULE11
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_line_released_idle: assert property (@(posedge clk) disable iff (rst)
    (state_reg != RTCSP_READ) |-> serial_data_io_oe_n) // RULE21
    else $error("data line driven outside read byte");

  chk_mode_latch_level: assert property (@(posedge clk) disable iff (rst)
    (clk_en && state_reg == RTCSP_IDLE && ce_rise) |=>
    (mode_reg == $past(sclk_s))) // RULE2
    else $error("edge mode not taken from clock level");

  chk_cmd_addr_load: assert property (@(posedge clk) disable iff (rst)
    (clk_en && ce_s && state_reg == RTCSP_CMD && byte_done) |=>
    (addr_reg == $past(in_byte[7:4])) &&
    (fmt_reg == $past(in_byte[3:0]))) // RULE5
    else $error("command byte not loaded");

  chk_burst_addr_incr: assert property (@(posedge clk) disable iff (rst)
    (clk_en && ce_s && byte_done && !single_fmt &&
    (state_reg == RTCSP_WRITE || state_reg == RTCSP_READ)) |=>
    (addr_reg == $past(addr_reg) + 4'h1)) // RULE8
    else $error("burst pointer did not advance");

  chk_single_write_return: assert property (@(posedge clk) disable iff (rst)
    (clk_en && ce_s && byte_done && single_fmt &&
    state_reg == RTCSP_WRITE) |=> (state_reg == RTCSP_CMD)) // RULE7
    else $error("single write did not return to command");

  chk_read_msb_first: assert property (@(posedge clk) disable iff (rst)
    (clk_en && state_reg == RTCSP_READ && launch_edge &&
    bit_cnt_reg == 3'h0) |=>
    (serial_data_io_out == $past(reg_bus.rdata[7]))) // RULE6
    else $error("read byte not started with top bit");

  chk_session_end_idle: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !ce_s) |=> (state_reg == RTCSP_IDLE) &&
    serial_data_io_oe_n) // RULE4
    else $error("session not closed by enable low");

  chk_hold_release: assert property (@(posedge clk) disable iff (rst)
    (clk_en && !ce_s) |=> !carry_hold) // RULE11
    else $error("carry hold kept after enable low");

  cov_burst_read: cover property (@(posedge clk) disable iff (rst)
    state_reg == RTCSP_READ && byte_done && !single_fmt);
  cov_single_write: cover property (@(posedge clk) disable iff (rst)
    reg_bus.wr_en && single_fmt);
  cov_mode_high: cover property (@(posedge clk) disable iff (rst)
    mode_reg && state_reg == RTCSP_READ);

endmodule

`default_nettype wire
